// [pkg/rsc_pkg.sv]
/*
 * rsc_pkg: constants, register map and carrier types for the reset
 * source controller.
 * assumes a 200 MHz system clock and 32-bit apb register access.
 */
package rsc_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned POR_HOLD_US      = 50;
  localparam int unsigned POR_HOLD_CYC     = POR_HOLD_US * CLK_MHZ;
  localparam int unsigned LVD_STAB_US      = 20;
  localparam int unsigned LVD_STAB_CYC     = LVD_STAB_US * CLK_MHZ;
  localparam int unsigned WDT_HOLD_NS      = 500;
  localparam int unsigned WDT_HOLD_CYC     = (WDT_HOLD_NS * CLK_MHZ) / 1000;
  localparam int unsigned SW_HOLD_NS       = 250;
  localparam int unsigned SW_HOLD_CYC      = (SW_HOLD_NS * CLK_MHZ) / 1000;
  localparam int unsigned PAR_HOLD_CYC     = SW_HOLD_CYC;
  localparam int unsigned CNT_W            = 24;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [11:0] ADDR_CAUSE_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_COLD_STATUS = 12'h004;
  localparam logic [11:0] ADDR_OPTION_WORD = 12'h008;
  localparam logic [11:0] ADDR_MON1_CTRL   = 12'h00c;
  localparam logic [11:0] ADDR_RESTART_REQ = 12'h010;
  localparam logic [11:0] ADDR_WDT_CTRL    = 12'h014;

  // cause flag bit positions
  localparam int unsigned CF_PIN  = 0;
  localparam int unsigned CF_WDT  = 1;
  localparam int unsigned CF_LVD0 = 2;
  localparam int unsigned CF_LVD1 = 3;
  localparam int unsigned CF_PAR  = 4;
  localparam int unsigned CF_SW   = 5;
  localparam int unsigned CF_BRN  = 6;
  localparam int unsigned CF_W    = 7;

  // option word / control fields
  localparam int unsigned OPT_PIN_ROLE   = 0;
  localparam int unsigned OPT_MON0_EN    = 1;
  localparam int unsigned OPT_MON0_RST   = 2;
  localparam int unsigned OPT_MON0_LVL_L = 4;
  localparam int unsigned MON1_EN        = 0;
  localparam int unsigned MON1_RST       = 1;
  localparam int unsigned MON1_LVL_L     = 8;
  localparam int unsigned WDT_NMI_SEL    = 0;
  localparam int unsigned RESTART_BIT    = 2;
  localparam int unsigned COLD_BIT       = 0;
  localparam logic [2:0]  MON0_LVL_MAX   = 3'h5;
  localparam logic [4:0]  MON1_LVL_MAX   = 5'h11;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic       pin_role;
    logic       mon0_en;
    logic       mon0_rst;
    logic [2:0] mon0_lvl;
  } rsc_opt_s;

  typedef struct packed {
    logic       mon1_en;
    logic       mon1_rst;
    logic [4:0] mon1_lvl;
  } rsc_mon1_s;

  typedef struct packed {
    logic por_below;
    logic wdt_event;
    logic mon0_below;
    logic mon1_below;
    logic parity_err;
  } rsc_evt_s;

  typedef enum logic [1:0] {
    ST_HOLD  = 2'b00,
    ST_RUN   = 2'b01,
    ST_TIMED = 2'b11
  } rsc_state_e;

endpackage : rsc_pkg

// [rtl/rsc_top.sv]
/*
 * rsc_top: merges seven reset sources into one internal reset, times
 * its release and records the cause for software over apb.
 * assumes analog comparators and the pin are asynchronous, the
 * watchdog and parity inputs come from logic on i_mclk.
 */
// Functional notes
// RL1 - internal reset from pin, por, watchdog, two monitors, parity, software
// RL2 - while clear pin samples low, hold the device in reset
// RL3 - board holds the clear pin low at least the minimum pulse width
// RL4 - after power-up line is reset input; option bit picks later role
// RL5 - general-port line held low before run keeps device in reset
// RL6 - pull-up on the reset line enabled once power is present
// RL7 - por release after supply above threshold plus full hold time
// RL8 - pin high and supply at or below threshold gives power-on reset
// RL9 - watchdog event gives reset or nmi; reset sets flag, short hold
// RL10 - each monitor low gives interrupt or reset; level fields 6 and 18
// RL11 - monitor reset released only after stabilisation interval
// RL12 - both monitors disabled after por; enabled by option word, control
// RL13 - monitor reset sets the brownout cause flag
// RL14 - restart request bit write 1 gives timed software reset
// RL15 - peripheral fault reset active without configuration
// RL16 - cold-start flag cleared only by power-on reset
// RL17 - cold-start flag set by writing 1, writing 0 has no effect
// RL18 - software writes cold-start flag 1 to detect a later por
// RL19 - readable cause flags name the last reset source incl software; the code keeps every flag set since the last por
// RL20 - internal reset release synchronised to the system clock
module rsc_top (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // pin and analog comparators
  input  wire logic               i_clear_pin,
  input  wire logic               i_por_below,
  input  wire logic               i_mon0_below,
  input  wire logic               i_mon1_below,
  // on-chip sources
  input  wire logic               i_wdt_event,
  input  wire logic               i_parity_err,
  // apb slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // outputs
  output logic                    o_sys_rst_n,
  output logic                    o_pullup_en,
  output logic                    o_nmi,
  output logic                    o_mon_irq,
  output logic [rsc_pkg::CF_W-1:0] o_cause
);

  // ==========================================================================
  // input synchronisers
  // only the second flop is read; the first may go metastable
  logic [3:0] sy1_q, sy2_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
    end else begin
      sy1_q <= {i_mon1_below, i_mon0_below, i_por_below, ~i_clear_pin};
      sy2_q <= sy1_q;
    end
  end
  logic pin_low, por_below, mon0_below, mon1_below;
  assign pin_low    = sy2_q[0];
  assign por_below  = sy2_q[1];
  assign mon0_below = sy2_q[2];
  assign mon1_below = sy2_q[3];

  // ==========================================================================
  // registers
  rsc_pkg::rsc_opt_s  opt_q;
  rsc_pkg::rsc_mon1_s mon1_q;
  logic               wdt_nmi_q;
  logic               cold_q;
  logic [rsc_pkg::CF_W-1:0] cause_q;
  logic               sw_req_q;
  logic               wr_en, rd_en;
  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && !i_penable && !i_pwrite;

  // ==========================================================================
  // reset sequencer
  rsc_pkg::rsc_state_e st_q;
  logic [rsc_pkg::CNT_W-1:0] cnt_q;
  logic por_q;
  logic mon0_trip, mon1_trip, wdt_trip, pin_hold;
  assign mon0_trip = opt_q.mon0_en && opt_q.mon0_rst && mon0_below; // RL10
  assign mon1_trip = mon1_q.mon1_en && mon1_q.mon1_rst && mon1_below; // RL10
  assign wdt_trip  = i_wdt_event && !wdt_nmi_q; // RL9
  // role 0 keeps the line a reset input; as a general port (role 1)
  // it still holds reset while low before run
  assign pin_hold  = pin_low &&
                     (!opt_q.pin_role || st_q != rsc_pkg::ST_RUN); // RL4 RL5

  // pin high and supply low: power-on reset, restarts hold time
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_q <= 1'b1;
    end else if (por_below && !pin_low) begin
      por_q <= 1'b1; // RL8
    end else if (st_q == rsc_pkg::ST_HOLD && cnt_q == '0) begin
      por_q <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q  <= rsc_pkg::ST_HOLD;
      cnt_q <= rsc_pkg::CNT_W'(rsc_pkg::POR_HOLD_CYC);
    end else if (por_below && !pin_low) begin
      st_q  <= rsc_pkg::ST_HOLD;
      cnt_q <= rsc_pkg::CNT_W'(rsc_pkg::POR_HOLD_CYC); // RL7
    end else if (pin_hold) begin
      st_q  <= rsc_pkg::ST_HOLD; // RL2
      // pin low during the power-on hold must not cut the hold short
      if (!por_q) cnt_q <= '0; // RL7
    end else if (mon0_trip || mon1_trip) begin
      st_q  <= rsc_pkg::ST_TIMED;
      cnt_q <= rsc_pkg::CNT_W'(rsc_pkg::LVD_STAB_CYC); // RL11
    end else begin
      unique case (st_q)
        rsc_pkg::ST_HOLD: begin
          if (cnt_q != '0) cnt_q <= cnt_q - 1'b1; // RL7
          else st_q <= rsc_pkg::ST_RUN;
        end
        rsc_pkg::ST_RUN: begin
          if (wdt_trip) begin
            st_q  <= rsc_pkg::ST_TIMED;
            cnt_q <= rsc_pkg::CNT_W'(rsc_pkg::WDT_HOLD_CYC); // RL9
          end else if (i_parity_err) begin
            st_q  <= rsc_pkg::ST_TIMED;
            cnt_q <= rsc_pkg::CNT_W'(rsc_pkg::PAR_HOLD_CYC); // RL15
          end else if (sw_req_q) begin
            st_q  <= rsc_pkg::ST_TIMED;
            cnt_q <= rsc_pkg::CNT_W'(rsc_pkg::SW_HOLD_CYC); // RL14
          end
        end
        rsc_pkg::ST_TIMED: begin
          if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
          else st_q <= rsc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // released on a clock edge from a flip-flop
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_rst_n <= 1'b0;
    end else begin
      o_sys_rst_n <= (st_q == rsc_pkg::ST_RUN) && !pin_hold; // RL1 RL20
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pullup_en <= 1'b0;
    end else begin
      o_pullup_en <= 1'b1; // RL6
    end
  end

  // interrupt outputs are registered copies of their causes
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nmi     <= 1'b0;
      o_mon_irq <= 1'b0;
    end else begin
      o_nmi     <= i_wdt_event && wdt_nmi_q; // RL9
      o_mon_irq <= (opt_q.mon0_en && !opt_q.mon0_rst && mon0_below) ||
                   (mon1_q.mon1_en && !mon1_q.mon1_rst && mon1_below); // RL10
    end
  end

  // ==========================================================================
  // configuration registers (monitors off after por)
  // writes during the power-on hold are dropped
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opt_q     <= '0;
      mon1_q    <= '0;
      wdt_nmi_q <= 1'b0;
    end else if (por_q) begin
      opt_q     <= '0; // RL12
      mon1_q    <= '0; // RL12
      wdt_nmi_q <= 1'b0;
    end else if (wr_en) begin
      unique case (i_paddr)
        rsc_pkg::ADDR_OPTION_WORD: begin
          opt_q.pin_role <= i_pwdata[rsc_pkg::OPT_PIN_ROLE]; // RL4
          opt_q.mon0_en  <= i_pwdata[rsc_pkg::OPT_MON0_EN]; // RL12
          opt_q.mon0_rst <= i_pwdata[rsc_pkg::OPT_MON0_RST];
          if (i_pwdata[rsc_pkg::OPT_MON0_LVL_L +: 3] <= rsc_pkg::MON0_LVL_MAX)
            opt_q.mon0_lvl <= i_pwdata[rsc_pkg::OPT_MON0_LVL_L +: 3]; // RL10
        end
        rsc_pkg::ADDR_MON1_CTRL: begin
          mon1_q.mon1_en  <= i_pwdata[rsc_pkg::MON1_EN]; // RL12
          mon1_q.mon1_rst <= i_pwdata[rsc_pkg::MON1_RST];
          if (i_pwdata[rsc_pkg::MON1_LVL_L +: 5] <= rsc_pkg::MON1_LVL_MAX)
            mon1_q.mon1_lvl <= i_pwdata[rsc_pkg::MON1_LVL_L +: 5]; // RL10
        end
        rsc_pkg::ADDR_WDT_CTRL: wdt_nmi_q <= i_pwdata[rsc_pkg::WDT_NMI_SEL];
        default: ;
      endcase
    end
  end

  // restart request: one-cycle pulse on write of 1
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_req_q <= 1'b0;
    end else begin
      sw_req_q <= wr_en && i_paddr == rsc_pkg::ADDR_RESTART_REQ &&
                  i_pwdata[rsc_pkg::RESTART_BIT] &&
                  st_q == rsc_pkg::ST_RUN; // RL14
    end
  end

  // ==========================================================================
  // cold-start flag: por clears, software write 1 sets
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cold_q <= 1'b0;
    end else if (por_q) begin
      cold_q <= 1'b0; // RL16
    end else if (wr_en && i_paddr == rsc_pkg::ADDR_COLD_STATUS &&
                 i_pwdata[rsc_pkg::COLD_BIT]) begin
      cold_q <= 1'b1; // RL17 RL18
    end
  end

  // cause flags: por clears all, each reset sets its flag
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_q <= '0;
    end else if (por_q) begin
      cause_q <= '0; // RL16
    end else begin
      if (pin_hold) cause_q[rsc_pkg::CF_PIN] <= 1'b1; // RL19
      if (st_q == rsc_pkg::ST_RUN && wdt_trip)
        cause_q[rsc_pkg::CF_WDT] <= 1'b1; // RL9
      if (mon0_trip) cause_q[rsc_pkg::CF_LVD0] <= 1'b1;
      if (mon1_trip) cause_q[rsc_pkg::CF_LVD1] <= 1'b1;
      if (mon0_trip || mon1_trip) cause_q[rsc_pkg::CF_BRN] <= 1'b1; // RL13
      if (st_q == rsc_pkg::ST_RUN && i_parity_err && !wdt_trip)
        cause_q[rsc_pkg::CF_PAR] <= 1'b1; // RL15
      if (sw_req_q) cause_q[rsc_pkg::CF_SW] <= 1'b1; // RL19
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cause <= '0;
    end else begin
      o_cause <= cause_q;
    end
  end

  // ==========================================================================
  // apb: pready answers every setup cycle, so no access waits;
  // unmapped addresses read zero and report an error
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (rd_en) begin
        unique case (i_paddr)
          rsc_pkg::ADDR_CAUSE_FLAGS: o_prdata <= {25'h0, cause_q};
          rsc_pkg::ADDR_COLD_STATUS: o_prdata <= {31'h0, cold_q};
          rsc_pkg::ADDR_OPTION_WORD: o_prdata <= {25'h0, opt_q.mon0_lvl, 1'b0,
              opt_q.mon0_rst, opt_q.mon0_en, opt_q.pin_role};
          rsc_pkg::ADDR_MON1_CTRL:   o_prdata <= {19'h0, mon1_q.mon1_lvl,
              6'h0, mon1_q.mon1_rst, mon1_q.mon1_en};
          rsc_pkg::ADDR_WDT_CTRL:    o_prdata <= {31'h0, wdt_nmi_q};
          rsc_pkg::ADDR_RESTART_REQ: o_prdata <= '0;
          default: begin
            o_prdata  <= '0;
            o_pslverr <= 1'b1;
          end
        endcase
      end else if (i_psel && !i_penable) begin
        o_prdata  <= '0;
        o_pslverr <= !(i_paddr == rsc_pkg::ADDR_CAUSE_FLAGS ||
                       i_paddr == rsc_pkg::ADDR_COLD_STATUS ||
                       i_paddr == rsc_pkg::ADDR_OPTION_WORD ||
                       i_paddr == rsc_pkg::ADDR_MON1_CTRL ||
                       i_paddr == rsc_pkg::ADDR_WDT_CTRL ||
                       i_paddr == rsc_pkg::ADDR_RESTART_REQ);
      end
    end
  end

endmodule // rsc_top

// [tb/rsc_board.sv]
/*
 * rsc_board: board reset driver and supply comparators.
 * assumes one bench process calls its tasks at a time.
 */
module rsc_board #(
  parameter int MIN_PULSE = 4
) (
  // clock
  input  wire logic i_mclk,
  // pin and comparators
  output logic      o_clear_pin_n,
  output logic      o_por_below,
  output logic      o_mon0_below,
  output logic      o_mon1_below
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // idle: pin left to its pull-up, supply good
  initial begin
    o_clear_pin_n = 1'h1;
    o_por_below   = 1'h0;
    o_mon0_below  = 1'h0;
    o_mon1_below  = 1'h0;
  end

  task automatic pulse_pin(input int w);
    @(posedge i_mclk);
    o_clear_pin_n <= 1'h0;
    repeat ((w > MIN_PULSE) ? w : MIN_PULSE) @(posedge i_mclk);
    o_clear_pin_n <= 1'h1;
  endtask

  // 0 power-on, 1 monitor zero, 2 monitor one
  task automatic set_lvl(input int k, input logic v);
    @(posedge i_mclk);
    case (k)
      0: o_por_below <= v;
      1: o_mon0_below <= v;
      default: o_mon1_below <= v;
    endcase
  endtask
endmodule // rsc_board

// [tb/rsc_top_chk.sv]
/*
 * rsc_top_chk: port assertions for the reset source controller.
 * assumes it is bound into rsc_top.
 */
module rsc_top_chk (
  // clock and reset
  input wire logic                     i_mclk,
  input wire logic                     i_rst_n,
  // sources
  input wire logic                     i_clear_pin,
  input wire logic                     i_por_below,
  input wire logic                     i_wdt_event,
  input wire logic                     i_parity_err,
  // apb
  input wire logic                     i_psel,
  input wire logic                     i_penable,
  input wire logic                     i_pwrite,
  input wire logic [11:0]              i_paddr,
  input wire logic [31:0]              i_pwdata,
  input wire logic [31:0]              o_prdata,
  input wire logic                     o_pready,
  input wire logic                     o_pslverr,
  // outputs
  input wire logic                     o_sys_rst_n,
  input wire logic                     o_pullup_en,
  input wire logic                     o_nmi,
  input wire logic [rsc_pkg::CF_W-1:0] o_cause
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // cycles since power came up or the supply last dipped
  int unsigned cnt_q;
  logic        acc;
  assign acc = i_psel && i_penable && o_pready;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_q <= 0;
    else if (i_por_below) cnt_q <= 0;
    else if (cnt_q < rsc_pkg::POR_HOLD_CYC) cnt_q <= cnt_q + 1;
  end

  // pin role as last written; power-on returns it to reset input
  logic        role_q;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      role_q <= 1'b0;
    end else if (i_por_below && i_clear_pin) begin
      role_q <= 1'b0;
    end else if (acc && i_pwrite && i_paddr == rsc_pkg::ADDR_OPTION_WORD) begin
      role_q <= i_pwdata[rsc_pkg::OPT_PIN_ROLE];
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_PIN_RST: assert property (
    (!role_q && !i_clear_pin) [*3] |-> ##[0:2] !o_sys_rst_n)
    else $error("pin reset");
  AST_PIN_FLAG: assert property (
    (!role_q && !i_clear_pin) [*3] |-> ##[0:3] o_cause[rsc_pkg::CF_PIN])
    else $error("pin flag");
  AST_POR_RST: assert property (
    (i_clear_pin && i_por_below) [*3] |-> ##[0:2] !o_sys_rst_n)
    else $error("por reset");
  AST_POR_HOLD: assert property (
    $rose(o_sys_rst_n) |-> cnt_q >= rsc_pkg::POR_HOLD_CYC)
    else $error("early release");
  AST_SW_RST: assert property (
    acc && i_pwrite && i_paddr == rsc_pkg::ADDR_RESTART_REQ
    && i_pwdata[rsc_pkg::RESTART_BIT] && o_sys_rst_n
    |-> ##[1:4] !o_sys_rst_n) else $error("sw reset");
  AST_WDT_ACT: assert property (
    i_wdt_event && o_sys_rst_n |-> ##[1:3] (!o_sys_rst_n || o_nmi))
    else $error("wdt action");
  AST_PAR_RST: assert property (
    i_parity_err && o_sys_rst_n |-> ##[1:3] !o_sys_rst_n)
    else $error("parity reset");
  AST_FLAG_KEEP: assert property (
    cnt_q > 16 |-> (o_cause & $past(o_cause)) == $past(o_cause))
    else $error("flag lost");
  AST_PULLUP: assert property (
    o_sys_rst_n |-> o_pullup_en) else $error("pull-up off");
  AST_APB_RDY: assert property (
    i_psel && !i_penable |=> o_pready) else $error("no ready");
  AST_APB_ERR: assert property (
    acc && i_paddr > rsc_pkg::ADDR_WDT_CTRL |-> o_pslverr && o_prdata == '0)
    else $error("unmapped");

  cover property (o_nmi);
  cover property (acc && o_pslverr);
  cover property ($rose(o_sys_rst_n));
  cover property (role_q && !i_clear_pin && o_sys_rst_n);
endmodule // rsc_top_chk

bind rsc_top rsc_top_chk rsc_top_chk_i (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_clear_pin(i_clear_pin),
  .i_por_below(i_por_below), .i_wdt_event(i_wdt_event),
  .i_parity_err(i_parity_err), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_sys_rst_n(o_sys_rst_n), .o_pullup_en(o_pullup_en), .o_nmi(o_nmi),
  .o_cause(o_cause));

// [tb/rsc_top_tb.sv]
/*
 * rsc_top_tb: apb-driven tests of the reset source controller.
 * assumes rsc_board drives the pin and comparators.
 */
module rsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic        mclk, rst_n, wdt_evt, par_err, psel, penable, pwrite, er, seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_c;
  logic        pready, pslverr, sys_rst_n, pullup_en, nmi, mon_irq;
  logic        clear_pin_n, por_below, mon0_below, mon1_below;
  logic [rsc_pkg::CF_W-1:0] cause;
  int          bad_count, checks, n;
  int          pos[3] = '{rsc_pkg::CF_PIN, rsc_pkg::CF_WDT, rsc_pkg::CF_PAR};

  always #2.5 mclk = ~mclk;

  rsc_board rsc_board_i (.i_mclk(mclk), .o_clear_pin_n(clear_pin_n),
    .o_por_below(por_below), .o_mon0_below(mon0_below),
    .o_mon1_below(mon1_below));
  rsc_top rsc_top_i (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_clear_pin(clear_pin_n), .i_por_below(por_below),
    .i_mon0_below(mon0_below), .i_mon1_below(mon1_below),
    .i_wdt_event(wdt_evt), .i_parity_err(par_err), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_sys_rst_n(sys_rst_n), .o_pullup_en(pullup_en),
    .o_nmi(nmi), .o_mon_irq(mon_irq), .o_cause(cause));

  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask

  task automatic cause_is(input logic [31:0] e);
    apb(1'h0, rsc_pkg::ADDR_CAUSE_FLAGS, 32'h0);
    chk("cause", e, rd);
    chk("cause_out", e, {25'h0, cause});
  endtask

  task automatic wait_rst(input logic lvl);
    n = 0;
    while (sys_rst_n !== lvl && n < 30000) begin
      @(posedge mclk);
      n++;
    end
    chk("rst_level", {31'h0, lvl}, {31'h0, sys_rst_n});
  endtask

  task automatic pulse(input logic wd);
    @(posedge mclk);
    {wdt_evt, par_err} <= {wd, !wd};
    @(posedge mclk);
    {wdt_evt, par_err} <= 2'h0;
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(5.0 * 40000);
    bad_count++;
    end_of_test();
  end

  // ==========================================================================
  // tests
  initial begin
    {mclk, rst_n, wdt_evt, par_err, psel, penable, pwrite} = 7'h0;
    {paddr, pwdata, exp_c} = 76'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'h1;
    wait_rst(1'h1);
    chk("por_len", 32'h1, n >= rsc_pkg::POR_HOLD_CYC);
    cause_is(32'h0);
    for (int k = 0; k < 3; k++) begin
      apb(k != 0, rsc_pkg::ADDR_COLD_STATUS, {31'h0, k == 2});
      apb(1'h0, rsc_pkg::ADDR_COLD_STATUS, 32'h0);
      chk("cold", k == 2, rd);
    end
    apb(1'h0, 12'h018, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, rd);
    rsc_board_i.set_lvl(1, 1'h1);
    repeat (8) @(posedge mclk);
    chk("mon_off", 32'h1, {mon_irq, sys_rst_n});
    apb(1'h1, rsc_pkg::ADDR_OPTION_WORD, 32'h2);
    repeat (8) @(posedge mclk);
    chk("mon0_irq", 32'h1, mon_irq);
    rsc_board_i.set_lvl(1, 1'h0);
    apb(1'h1, rsc_pkg::ADDR_WDT_CTRL, 32'h1);
    pulse(1'h1);
    seen = 1'h0;
    repeat (4) begin
      @(posedge mclk);
      seen |= nmi;
    end
    chk("nmi", 32'h3, {seen, sys_rst_n});
    apb(1'h1, rsc_pkg::ADDR_WDT_CTRL, 32'h0);
    apb(1'h1, rsc_pkg::ADDR_RESTART_REQ, 32'h4);
    wait_rst(1'h0);
    wait_rst(1'h1);
    chk("sw_hold", 32'h1, n >= rsc_pkg::SW_HOLD_CYC);
    exp_c[rsc_pkg::CF_SW] = 1'h1;
    cause_is(exp_c);
    apb(1'h1, rsc_pkg::ADDR_OPTION_WORD, 32'h3);
    rsc_board_i.pulse_pin(2);
    repeat (4) @(posedge mclk);
    chk("pin_port", 32'h1, sys_rst_n);
    cause_is(exp_c);
    apb(1'h1, rsc_pkg::ADDR_OPTION_WORD, 32'h2);
    for (int k = 0; k < 3; k++) begin
      if (k == 0) rsc_board_i.pulse_pin(2);
      else pulse(k == 1);
      wait_rst(1'h0);
      wait_rst(1'h1);
      exp_c[pos[k]] = 1'h1;
      cause_is(exp_c);
    end
    apb(1'h1, rsc_pkg::ADDR_MON1_CTRL, 32'h3);
    rsc_board_i.set_lvl(2, 1'h1);
    wait_rst(1'h0);
    rsc_board_i.set_lvl(2, 1'h0);
    wait_rst(1'h1);
    chk("stab", 32'h1, n >= rsc_pkg::LVD_STAB_CYC);
    exp_c[rsc_pkg::CF_LVD1] = 1'h1;
    exp_c[rsc_pkg::CF_BRN] = 1'h1;
    cause_is(exp_c);
    rsc_board_i.set_lvl(0, 1'h1);
    repeat (8) @(posedge mclk);
    rsc_board_i.set_lvl(0, 1'h0);
    chk("por_rst", 32'h0, sys_rst_n);
    cause_is(32'h0);
    apb(1'h0, rsc_pkg::ADDR_COLD_STATUS, 32'h0);
    chk("cold_por", 32'h0, rd);
    apb(1'h0, rsc_pkg::ADDR_OPTION_WORD, 32'h0);
    chk("opt_por", 32'h0, rd);
    end_of_test();
  end
endmodule // rsc_top_tb
